// *** szt_unit.v ***
`timescale 1ns/100ps
`include "szt_defs.vh"
module szt_unit (
  input  wire        clk_i,
  input  wire        rst_b_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_we_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         test_flag_o,
  output reg         busy_o
);
  // ****************************************************************
  // sequencer states
  // ****************************************************************
  localparam ST_IDLE  = 4'b0001;
  localparam ST_PRE   = 4'b0010;
  localparam ST_T6    = 4'b0100;
  localparam ST_DONE  = 4'b1000;

  reg [3:0]  state_reg;
  reg [23:0] instr_reg;
  reg [23:0] accum_reg;
  reg [4:0]  count_reg;
  reg        test_flag;
  reg        serial_carry_flop;
  reg [14:0] pc_reg;

  wire wb_hit               = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr                   = wb_hit & wb_we_i;
  wire generic_op_decode    = ~state_reg[0];
  wire time6_envelope       = state_reg[2];
  wire count_terminal_reached = (count_reg == `SZT_CNT_TERM);
  wire zero_test_complement_op = instr_reg[`SZT_IR_COMP];
  wire zero_test_op         = ~instr_reg[`SZT_IR_COMP];
  wire accum_shift_pulse    = generic_op_decode & time6_envelope &
                              ~count_terminal_reached;
  wire adder_a              = accum_reg[0];
  // other adder inputs are inhibited, so sum is a0 xor carry
  wire adder_sum            = adder_a ^ serial_carry_flop;
  wire start = wr & (wb_adr_i == `SZT_ADR_CTRL) & wb_sel_i[0] &
               wb_dat_i[`SZT_CTRL_START] & state_reg[0];

  // ****************************************************************
  // execution
  // ****************************************************************
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg         <= ST_IDLE;
      count_reg         <= `SZT_CNT_RST;
      test_flag         <= 1'b0;
      serial_carry_flop <= 1'b0;
      pc_reg            <= `SZT_PC_RST;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_PRE;
          end
        end
        ST_PRE: begin
          count_reg         <= ~instr_reg[4:0];
          test_flag         <= 1'b1;
          // carry held set for complement, reset for plain test
          serial_carry_flop <= zero_test_complement_op;
          state_reg         <= ST_T6;
        end
        ST_T6: begin
          if (accum_shift_pulse) begin
            count_reg <= count_reg + 5'h01;
            if (adder_a) begin
              test_flag <= 1'b0;
            end
          end else begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          pc_reg            <= pc_reg + 15'h0001;
          serial_carry_flop <= 1'b0;
          state_reg         <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // accumulator shared between bus and shifter; bus writes only when idle
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      accum_reg <= `SZT_ACC_RST;
      instr_reg <= `SZT_IR_RST;
    end else if (accum_shift_pulse) begin
      accum_reg <= {adder_sum, accum_reg[23:1]};
    end else if (wr & state_reg[0]) begin
      if (wb_adr_i == `SZT_ADR_ACCUM) begin
        if (wb_sel_i[0]) accum_reg[7:0]   <= wb_dat_i[7:0];
        if (wb_sel_i[1]) accum_reg[15:8]  <= wb_dat_i[15:8];
        if (wb_sel_i[2]) accum_reg[23:16] <= wb_dat_i[23:16];
      end
      if (wb_adr_i == `SZT_ADR_INSTR) begin
        if (wb_sel_i[0]) instr_reg[7:0]   <= wb_dat_i[7:0];
        if (wb_sel_i[1]) instr_reg[15:8]  <= wb_dat_i[15:8];
        if (wb_sel_i[2]) instr_reg[23:16] <= wb_dat_i[23:16];
      end
    end
  end

  // ****************************************************************
  // wishbone slave: ack one cycle after strobe, unmapped reads zero
  // ****************************************************************
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h00000000;
      test_flag_o <= 1'b0;
      busy_o      <= 1'b0;
    end else begin
      wb_ack_o    <= wb_hit;
      test_flag_o <= test_flag;
      busy_o      <= ~state_reg[0];
      wb_dat_o    <= 32'h00000000;
      if (wb_hit & ~wb_we_i) begin
        case (wb_adr_i)
          `SZT_ADR_CTRL:   wb_dat_o <= {17'h00000, pc_reg};
          `SZT_ADR_INSTR:  wb_dat_o <= {8'h00, instr_reg};
          `SZT_ADR_ACCUM:  wb_dat_o <= {8'h00, accum_reg};
          `SZT_ADR_STATUS: wb_dat_o <= {19'h00000, count_reg,
                                        6'h00, test_flag, ~state_reg[0]};
          default:         wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// *** szt_defs.vh ***
`ifndef SZT_DEFS_VH
`define SZT_DEFS_VH
// ****************************************************************
// register map (word byte addresses)
// ****************************************************************
`define SZT_ADR_CTRL    4'h0
`define SZT_ADR_INSTR   4'h4
`define SZT_ADR_ACCUM   4'h8
`define SZT_ADR_STATUS  4'hC
`define SZT_ADR_PC      4'h0
// ****************************************************************
// field positions
// ****************************************************************
`define SZT_CTRL_START  0
`define SZT_ST_BUSY     0
`define SZT_ST_TEST     1
`define SZT_ST_CNT_LSB  8
`define SZT_IR_COMP     6
// ****************************************************************
// constants and reset values
// ****************************************************************
`define SZT_CNT_TERM    5'h1F
`define SZT_CNT_RST     5'h00
`define SZT_ACC_RST     24'h000000
`define SZT_IR_RST      24'h000000
`define SZT_PC_RST      15'h0000
`endif

// *** szt_unit_properties.sv ***
`timescale 1ns/100ps
module szt_chk (
  input wire        clk_i,
  input wire        rst_b_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        test_flag_o,
  input wire        busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack too long");
  property p_take; wb_ack_o |-> $past(wb_cyc_i & wb_stb_i & !wb_ack_o);
  endproperty
  a_take: assert property (p_take) else $error("ack without request");
  property p_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat: assert property (p_dat) else $error("read data outside ack");
  property p_set; $rose(busy_o) |-> ##[0:2] test_flag_o; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_hold; $fell(test_flag_o) ##1 busy_o |-> !test_flag_o; endproperty
  a_hold: assert property (p_hold) else $error("flag rose");
  property p_len; $rose(busy_o) |-> busy_o [*8] ##[14:22] !busy_o; endproperty
  a_len: assert property (p_len) else $error("bad run length");
  property p_idle; !busy_o && !$past(busy_o) |-> $stable(test_flag_o);
  endproperty
  a_idle: assert property (p_idle) else $error("idle flag move");
  property p_shift; $fell(test_flag_o) |-> $past(busy_o); endproperty
  a_shift: assert property (p_shift) else $error("idle clear");
endmodule
bind szt_unit szt_chk i_chk (.clk_i, .rst_b_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .test_flag_o, .busy_o);

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  reg         clk_i = 0;
  reg         rst_b_i = 0;
  reg  [3:0]  wb_adr_i = 4'h0;
  reg  [31:0] wb_dat_i = 32'h0;
  reg  [3:0]  wb_sel_i = 4'hF;
  reg         wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o, test_flag_o, busy_o;
  integer     n_errors = 0, compares = 0, sd = 54, pc = 0, i, k;
  reg  [23:0] a;
  reg  [31:0] r;
  szt_unit i_dut (.clk_i, .rst_b_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .test_flag_o,
    .busy_o);
  initial forever #25 clk_i = ~clk_i;
  task give_verdict; begin
    if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  end endtask
  task chk(input [31:0] s, input [31:0] e); begin
    compares = compares + 1;
    if (s !== e) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED %0t got %h exp %h", $time, s, e);
    end
  end endtask
  // hold the request until ack is sampled, then idle one cycle
  task bus(input [3:0] ad, input w, input [31:0] d); begin
    wb_adr_i <= ad;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    k = 0;
    do begin @(posedge clk_i); k = k + 1; end
    while (wb_ack_o !== 1'b1 && k < 9);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    if (k >= 9) begin n_errors = n_errors + 1; give_verdict; end
  end endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    for (i = 0; i < 12; i = i + 1) begin
      a = i < 2 ? 24'h0 : i < 4 ? 24'hFFFFFF : i < 6 ? 24'h800000 :
          i < 8 ? 24'h000001 : $random(sd);
      // bits 4..3 set, 2..0 clear: preset count 7 gives 24 shifts
      bus(4'h4, 1'b1, i[0] ? 32'h58 : 32'h18);
      bus(4'h8, 1'b1, {8'h0, a});
      bus(4'h0, 1'b1, 32'h1);
      // written while busy: must be ignored; count is already preset in ST_PRE, so shifts happen either way
      bus(4'h4, 1'b1, 32'h0);
      k = 0;
      while (busy_o !== 1'b0 && k < 60) begin @(posedge clk_i); k = k + 1; end
      if (k >= 60) begin n_errors = n_errors + 1; give_verdict; end
      chk(busy_o, 1'b0);
      pc = pc + 1;
      bus(4'h8, 1'b0, 0); chk(r, {8'h0, i[0] ? ~a : a});
      bus(4'hC, 1'b0, 0); chk(r, {19'h0, 5'h1F, 6'h0, a == 0, 1'b0});
      chk(test_flag_o, a == 0);
      bus(4'h0, 1'b0, 0); chk(r, pc & 32'h7FFF);
    end
    bus(4'h2, 1'b0, 0); chk(r, 32'h0);
    give_verdict;
  end
endmodule
